// ===== rtl/eie_pkg.sv
// constants and carrier types for the extra external interrupt block
// assumes an 8-bit core that reaches special-function registers by byte and by bit
package eie_pkg;

  // special-function byte addresses
  localparam logic [7:0] EIE_CTRL_ADDR   = 8'hc0;
  localparam logic [7:0] EIE_PORT_ADDR   = 8'hd8;

  // reset values
  localparam logic [7:0] EIE_CTRL_RESET  = 8'h00;
  localparam logic [7:0] EIE_PORT_RESET  = 8'hff;

  // control register field positions
  localparam int         EIE_IT_A        = 0;
  localparam int         EIE_FLAG_A      = 1;
  localparam int         EIE_EN_A        = 2;
  localparam int         EIE_PRIO_A      = 3;
  localparam int         EIE_IT_B        = 4;
  localparam int         EIE_FLAG_B      = 5;
  localparam int         EIE_EN_B        = 6;
  localparam int         EIE_PRIO_B      = 7;

  // standard register bits the core hands in
  localparam int         EIE_TC_IT0      = 0;
  localparam int         EIE_TC_IT1      = 2;
  localparam int         EIE_IE_ALL      = 7;

  // source numbers, equal to polling order
  localparam logic [2:0] EIE_SRC_EXT0    = 3'h0;
  localparam logic [2:0] EIE_SRC_EXT1    = 3'h2;
  localparam logic [2:0] EIE_SRC_A       = 3'h6;
  localparam logic [2:0] EIE_SRC_B       = 3'h7;

  // vector = base + 8 * source
  localparam logic [7:0] EIE_VEC_BASE    = 8'h03;

  // pin slots in the synchroniser: port bits 0..3, then ext0, ext1
  localparam int         EIE_PIN_EXT0    = 4;
  localparam int         EIE_PIN_EXT1    = 5;
  localparam int         EIE_PIN_A       = 2;
  localparam int         EIE_PIN_B       = 3;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] bit_addr;
    logic       bit_wr;
    logic       bit_val;
    logic       bit_rd;
  } eie_sfr_t;

  typedef struct packed {
    logic       ack;
    logic       reti;
  } eie_core_t;

endpackage : eie_pkg

// ===== rtl/eie_detect.sv
// one external interrupt request flag with edge or level detection
// assumes its pin input has already been synchronised to clock
`timescale 1ns/1ps
module eie_detect
  import eie_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // pin and mode
  input  wire logic pin_n,
  input  wire logic edge_mode,
  // software and service
  input  wire logic sw_wr,
  input  wire logic sw_val,
  input  wire logic svc_clr,
  // flag
  output logic      flag
);

  typedef struct packed {
    logic prev;
    logic flag;
  } eie_det_st_t;

  eie_det_st_t st_reg;
  eie_det_st_t st_next;

  always_comb
  begin
    st_next      = st_reg;
    st_next.prev = pin_n;
    if (edge_mode)
    begin
      // set wins over a clear in the same cycle
      if (st_reg.prev && !pin_n)
        st_next.flag = 1'b1;                           // [R5] [R6]
      else if (sw_wr)
        st_next.flag = sw_val;
      else if (svc_clr)
        st_next.flag = 1'b0;                           // [R6]
    end
    else
      st_next.flag = !pin_n;                           // [R5]
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      st_reg <= '{prev: 1'b1, flag: 1'b0};
    else
      st_reg <= st_next;
  end

  assign flag = st_reg.flag;

endmodule : eie_detect

// ===== rtl/eie_top.sv
// extra external interrupts, their control register, the auxiliary port
// and the eight-source vector and polling logic
// assumes the core owns the standard enable, priority and timer registers
// Function
// R1 - two extra active-low interrupts, control at c0h
// R2 - bit set and clear reach every control bit
// R3 - priority bit selects high or low level
// R4 - request forwarded only when its enable set
// R5 - trigger bit: falling edge, else low level
// R6 - edge flag set by hardware, cleared on service
// R7 - first extra: vector 33h, polled seventh
// R8 - second extra: vector 3bh, polled last
// R9 - six standard sources: vectors, order, enables
// R10 - timer control bits 0,2 pick ext0/ext1 trigger
// R11 - auxiliary port d8h, low nibble quasi-bidirectional
// R12 - port bits 3,2 double as extra inputs
// R13 - any enabled interrupt ends idle
// R14 - reset clears control, port latch to ones
// R15 - high pre-empts low; ties by polling order
`timescale 1ns/1ps
module eie_top
  import eie_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // special-function register access
  input  wire eie_sfr_t   sfr,
  output logic [7:0]      sfr_rdata,
  output logic            bit_rdata,
  // standard interrupt state from the core
  input  wire logic [7:0] interrupt_enable_reg,
  input  wire logic [7:0] timer_control_reg,
  input  wire logic [5:0] std_prio,
  input  wire logic [5:0] std_req,
  input  wire eie_core_t  core,
  // requests to the core
  output logic            irq_req,
  output logic [2:0]      irq_src,
  output logic [7:0]      irq_vector,
  output logic            irq_high,
  output logic            wake,
  output logic            ext0_flag,
  output logic            ext1_flag,
  // pins
  input  wire logic [3:0] aux_port_in,
  input  wire logic       ext0_in_n,
  input  wire logic       ext1_in_n,
  output logic [3:0]      aux_port_out,
  output logic [3:0]      aux_port_oe
);

  typedef struct packed {
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [7:0] port_latch;
    logic [7:0] ctrl;
    logic [7:0] rdata;
    logic       bit_rdata;
    logic       req;
    logic [2:0] src;
    logic [7:0] vector;
    logic       high;
    logic       wake;
    logic [1:0] in_srv;
    logic [3:0] port_oe;
    logic       ext0_flag;
    logic       ext1_flag;
  } eie_st_t;

  eie_st_t    st_reg;
  eie_st_t    st_next;

  // detector hookup: 0 ext0, 1 ext1, 2 extra a, 3 extra b
  logic [3:0] det_pin;
  logic [3:0] det_mode;
  logic [3:0] det_wr;
  logic [3:0] det_val;
  logic [3:0] det_clr;
  logic [3:0] det_flag;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_det
      eie_detect u_det (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .pin_n     (det_pin[g]),
        .edge_mode (det_mode[g]),
        .sw_wr     (det_wr[g]),
        .sw_val    (det_val[g]),
        .svc_clr   (det_clr[g]),
        .flag      (det_flag[g])
      );
    end
  endgenerate

  logic [7:0] ctrl_view;
  logic [7:0] port_view;
  logic [7:0] ctrl_wr;
  logic [7:0] req;
  logic [7:0] prio;
  logic       hi_hit;
  logic       lo_hit;
  logic [2:0] hi_src;
  logic [2:0] lo_src;
  logic       ctrl_bit;
  logic       port_bit;

  always_comb
  begin
    st_next  = st_reg;
    hi_hit   = 1'b0;
    lo_hit   = 1'b0;
    hi_src   = 3'h0;
    lo_src   = 3'h0;
    // pins pass two flops before use
    st_next.sync1 = {ext1_in_n, ext0_in_n, aux_port_in};
    st_next.sync2 = st_reg.sync1;

    // extra inputs come off port bits 2 and 3
    det_pin  = {st_reg.sync2[EIE_PIN_B], st_reg.sync2[EIE_PIN_A],
                st_reg.sync2[EIE_PIN_EXT1], st_reg.sync2[EIE_PIN_EXT0]};   // [R12]
    det_mode = {st_reg.ctrl[EIE_IT_B], st_reg.ctrl[EIE_IT_A],
                timer_control_reg[EIE_TC_IT1],
                timer_control_reg[EIE_TC_IT0]};                            // [R5] [R10]

    ctrl_view = st_reg.ctrl;
    ctrl_view[EIE_FLAG_A] = det_flag[2];
    ctrl_view[EIE_FLAG_B] = det_flag[3];
    // pins read back; unusable upper half reads as latch ones
    port_view = {st_reg.port_latch[7:4], st_reg.sync2[3:0]};              // [R11]

    // byte or bit write into the control register
    ctrl_bit = sfr.bit_wr && (sfr.bit_addr[7:3] == EIE_CTRL_ADDR[7:3]);
    port_bit = sfr.bit_wr && (sfr.bit_addr[7:3] == EIE_PORT_ADDR[7:3]);
    ctrl_wr  = 8'h00;
    if (sfr.wr && sfr.addr == EIE_CTRL_ADDR)
    begin
      ctrl_wr = 8'hff;
      st_next.ctrl = sfr.wdata;                                            // [R1]
    end
    else if (ctrl_bit)
    begin
      ctrl_wr[sfr.bit_addr[2:0]] = 1'b1;
      st_next.ctrl[sfr.bit_addr[2:0]] = sfr.bit_val;                       // [R2]
    end
    // flags live in the detectors, keep the copy here at zero
    st_next.ctrl[EIE_FLAG_A] = 1'b0;
    st_next.ctrl[EIE_FLAG_B] = 1'b0;
    det_wr  = {ctrl_wr[EIE_FLAG_B], ctrl_wr[EIE_FLAG_A], 2'b00};
    // a byte write wins over a bit write in the same cycle
    det_val = {(&ctrl_wr ? sfr.wdata[EIE_FLAG_B] : sfr.bit_val),
               (&ctrl_wr ? sfr.wdata[EIE_FLAG_A] : sfr.bit_val), 2'b00};

    // port latch: only the low nibble is usable
    if (sfr.wr && sfr.addr == EIE_PORT_ADDR)
      st_next.port_latch[3:0] = sfr.wdata[3:0];                            // [R11]
    else if (port_bit && !sfr.bit_addr[2])
      st_next.port_latch[sfr.bit_addr[1:0]] = sfr.bit_val;
    // quasi-bidirectional: drive low only, ones are pulled up
    st_next.port_oe = ~st_next.port_latch[3:0];                           // [R11]

    // reads
    if (sfr.rd)
      st_next.rdata = (sfr.addr == EIE_CTRL_ADDR) ? ctrl_view :
                      (sfr.addr == EIE_PORT_ADDR) ? port_view : 8'h00;
    if (sfr.bit_rd)
      st_next.bit_rdata = (sfr.bit_addr[7:3] == EIE_CTRL_ADDR[7:3]) ?
                          ctrl_view[sfr.bit_addr[2:0]] :
                          (sfr.bit_addr[7:3] == EIE_PORT_ADDR[7:3]) ?
                          port_view[sfr.bit_addr[2:0]] : 1'b0;

    // gated requests in polling order
    req = {det_flag[3] & st_reg.ctrl[EIE_EN_B],
           det_flag[2] & st_reg.ctrl[EIE_EN_A],                            // [R4]
           std_req[5:3] & interrupt_enable_reg[5:3],
           det_flag[1] & interrupt_enable_reg[2],
           std_req[1] & interrupt_enable_reg[1],
           det_flag[0] & interrupt_enable_reg[0]};                         // [R9]
    req = req & {8{interrupt_enable_reg[EIE_IE_ALL]}};
    prio = {st_reg.ctrl[EIE_PRIO_B], st_reg.ctrl[EIE_PRIO_A], std_prio};   // [R3]
    // scan from source 7 down so the earliest source is kept
    for (int i = 7; i >= 0; i--)
    begin
      if (req[i] && prio[i])
      begin
        hi_hit = 1'b1;
        hi_src = 3'(i);                                                    // [R15]
      end
      if (req[i] && !prio[i])
      begin
        lo_hit = 1'b1;
        lo_src = 3'(i);                                                    // [R7] [R8]
      end
    end
    // a low routine only yields to high; a high one to nothing
    st_next.req  = 1'b0;
    st_next.high = 1'b0;
    st_next.src  = st_reg.src;
    if (!st_reg.in_srv[1] && hi_hit)
    begin
      st_next.req  = 1'b1;
      st_next.high = 1'b1;
      st_next.src  = hi_src;                                               // [R15]
    end
    else if (st_reg.in_srv == 2'b00 && lo_hit)
    begin
      st_next.req = 1'b1;
      st_next.src = lo_src;
    end
    st_next.vector = EIE_VEC_BASE + {2'b00, st_next.src, 3'b000};          // [R7] [R8] [R9]
    st_next.wake   = |req;                                                 // [R13]

    // service: the core takes the posted request
    det_clr = 4'h0;
    if (core.ack && st_reg.req)
    begin
      if (st_reg.high)
        st_next.in_srv[1] = 1'b1;
      else
        st_next.in_srv[0] = 1'b1;
      det_clr = {st_reg.src == EIE_SRC_B, st_reg.src == EIE_SRC_A,
                 st_reg.src == EIE_SRC_EXT1, st_reg.src == EIE_SRC_EXT0};  // [R6]
      // hold off one cycle so the cleared flag is not posted again
      st_next.req = 1'b0;
    end
    else if (core.reti)
    begin
      if (st_reg.in_srv[1])
        st_next.in_srv[1] = 1'b0;
      else
        st_next.in_srv[0] = 1'b0;
    end
    st_next.ext0_flag = det_flag[0];
    st_next.ext1_flag = det_flag[1];
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_reg            <= '0;
      st_reg.sync1      <= 6'h3f;
      st_reg.sync2      <= 6'h3f;
      st_reg.port_latch <= EIE_PORT_RESET;                                 // [R14]
      st_reg.ctrl       <= EIE_CTRL_RESET;                                 // [R14]
      st_reg.vector     <= EIE_VEC_BASE;
    end
    else
      st_reg <= st_next;
  end

  assign sfr_rdata    = st_reg.rdata;
  assign bit_rdata    = st_reg.bit_rdata;
  assign irq_req      = st_reg.req;
  assign irq_src      = st_reg.src;
  assign irq_vector   = st_reg.vector;
  assign irq_high     = st_reg.high;
  assign wake         = st_reg.wake;
  assign ext0_flag    = st_reg.ext0_flag;
  assign ext1_flag    = st_reg.ext1_flag;
  assign aux_port_out = 4'h0;
  assign aux_port_oe  = st_reg.port_oe;

endmodule : eie_top

// ===== tb/eie_properties.sv
// port assertions for the extra interrupt block
// assumes one clock domain with the synchronous high reset
`timescale 1ns/1ps
module eie_properties
  import eie_pkg::*;
(
  // clock and reset
  input wire logic       clock,
  input wire logic       sys_rst,
  // register side
  input wire eie_sfr_t   sfr,
  input wire logic [7:0] sfr_rdata,
  // core side
  input wire logic [7:0] interrupt_enable_reg,
  input wire logic [5:0] std_prio,
  input wire eie_core_t  core,
  input wire logic       irq_req,
  input wire logic [2:0] irq_src,
  input wire logic [7:0] irq_vector,
  input wire logic       irq_high,
  input wire logic       wake,
  // pins
  input wire logic [3:0] aux_port_out,
  input wire logic [3:0] aux_port_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_taken; core.ack; endsequence
  sequence s_gone; !irq_req; endsequence
  AST_VECTOR: assert property (
    irq_req |-> irq_vector == 8'h03 + {2'h0, irq_src, 3'h0})
    else $error("vector does not match source");
  AST_DROP: assert property (s_taken |=> s_gone)
    else $error("request stands after ack");
  AST_RESET: assert property (
    $fell(sys_rst) |-> aux_port_oe == 4'h0 && !irq_req && irq_vector == 8'h03)
    else $error("outputs not cleared by reset");
  AST_PAD_LOW: assert property (aux_port_out == 4'h0)
    else $error("pad level not low");
  AST_EXTRA_GATE: assert property (
    irq_req && irq_src >= 3'h6 |-> $past(interrupt_enable_reg[7]))
    else $error("extra request without global enable");
  AST_STD_GATE: assert property (
    irq_req && irq_src < 3'h6 |->
      ((($past(interrupt_enable_reg) >> irq_src) & 8'h01) != 8'h00))
    else $error("standard request without its enable");
  AST_STD_PRIO: assert property (
    irq_req && irq_src inside {3'h1, 3'h3, 3'h4, 3'h5} |->
      irq_high == ((($past(std_prio) >> irq_src) & 6'h01) != 6'h00))
    else $error("priority level mismatch");
  AST_WAKE: assert property (irq_req |-> wake)
    else $error("request without wake");
  AST_OE_CAUSE: assert property (
    $changed(aux_port_oe) |-> $past(sfr.wr || sfr.bit_wr))
    else $error("port drive changed without a write");
  AST_RDATA_HOLD: assert property (!$past(sfr.rd) |-> $stable(sfr_rdata))
    else $error("read data moved without a read");
endmodule : eie_properties

bind eie_top eie_properties eie_properties_i (.clock, .sys_rst, .sfr, .sfr_rdata,
  .interrupt_enable_reg, .std_prio, .core, .irq_req, .irq_src, .irq_vector,
  .irq_high, .wake, .aux_port_out, .aux_port_oe);

// ===== tb/eie_core_model.sv
// core handshake model: takes a posted request, ends its routine later
// assumes requests settle after the rising edge; answers on the falling one
`timescale 1ns/1ps
module eie_core_model
  import eie_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // handshake
  input  wire logic irq_req,
  output eie_core_t core
);
  int unsigned left = 0;
  initial core = '0;
  // one routine at a time, nesting is not modelled
  always @(negedge clock)
  begin
    if (sys_rst)
    begin
      left <= 0;
      core <= '0;
    end
    else if (left > 0)
    begin
      left <= left - 1;
      core <= '{ack: 1'b0, reti: (left == 1)};
    end
    else if (irq_req === 1'b1)
    begin
      core <= '{ack: 1'b1, reti: 1'b0};
      left <= 8;
    end
    else
      core <= '0;
  end
endmodule : eie_core_model

// ===== tb/eie_top_bench.sv
// self-checking bench for the extra interrupt block
// assumes the core model answers every posted request
`timescale 1ns/1ps
module eie_top_bench;
  import eie_pkg::*;
  typedef struct packed {
    logic [7:0] ie, tc;
    logic [5:0] req, prio;
    logic [1:0] ext_n;
    logic [7:0] ctrl;
    logic [3:0] pins;
    logic [2:0] src;
    logic       high;
  } eie_row_t;
  logic clock, sys_rst, bit_rdata, irq_req, irq_high, wake, ext0_in_n, ext1_in_n;
  logic ext0_flag, ext1_flag;
  logic [7:0] sfr_rdata, interrupt_enable_reg, timer_control_reg, irq_vector;
  logic [5:0] std_prio, std_req;
  logic [3:0] aux_port_in, aux_port_oe, pin_drive;
  logic [2:0] irq_src;
  eie_sfr_t   sfr;
  eie_core_t  core;
  eie_row_t   r;
  int failures = 0;
  int total_checks = 0;
  int n;
  eie_row_t rows [11] = '{
    '{8'h82, 8'h00, 6'h02, 6'h00, 2'h3, 8'h00, 4'hf, 3'h1, 1'b0},
    '{8'h88, 8'h00, 6'h08, 6'h00, 2'h3, 8'h00, 4'hf, 3'h3, 1'b0},
    '{8'h90, 8'h00, 6'h10, 6'h00, 2'h3, 8'h00, 4'hf, 3'h4, 1'b0},
    '{8'ha0, 8'h00, 6'h20, 6'h00, 2'h3, 8'h00, 4'hf, 3'h5, 1'b0},
    '{8'h81, 8'h00, 6'h00, 6'h00, 2'h2, 8'h00, 4'hf, 3'h0, 1'b0},
    '{8'h84, 8'h04, 6'h00, 6'h00, 2'h1, 8'h00, 4'hf, 3'h2, 1'b0},
    '{8'h80, 8'h00, 6'h00, 6'h00, 2'h3, 8'h05, 4'hb, 3'h6, 1'b0},
    '{8'h80, 8'h00, 6'h00, 6'h00, 2'h3, 8'h40, 4'h7, 3'h7, 1'b0},
    '{8'ha2, 8'h00, 6'h22, 6'h00, 2'h3, 8'h00, 4'hf, 3'h1, 1'b0},
    '{8'h92, 8'h00, 6'h12, 6'h10, 2'h3, 8'h00, 4'hf, 3'h4, 1'b1},
    '{8'h80, 8'h00, 6'h00, 6'h00, 2'h3, 8'h0d, 4'hb, 3'h6, 1'b1}};
  // pads pull up; a clear drive bit or a set output enable pulls the pin low
  assign aux_port_in = pin_drive & ~aux_port_oe;
  eie_top eie_top_i (.clock, .sys_rst, .sfr, .sfr_rdata, .bit_rdata,
    .interrupt_enable_reg, .timer_control_reg, .std_prio, .std_req, .core,
    .irq_req, .irq_src, .irq_vector, .irq_high, .wake, .ext0_flag, .ext1_flag,
    .aux_port_in, .ext0_in_n, .ext1_in_n, .aux_port_out(), .aux_port_oe);
  eie_core_model eie_core_model_i (.clock, .sys_rst, .irq_req, .core);
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic tick(int k);
    repeat (k) @(negedge clock);
  endtask : tick
  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    total_checks++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // k: byte write, byte read, bit write, bit read; idle cycle after each
  task automatic op(logic [3:0] k, logic [7:0] a, logic [7:0] d);
    sfr = '{addr: a, wdata: d, bit_addr: a, bit_val: d[0],
            wr: k[3], rd: k[2], bit_wr: k[1], bit_rd: k[0]};
    tick(1);
    sfr = '0;
    tick(1);
  endtask : op
  task automatic rd_chk(string nm, logic [7:0] a, logic [7:0] e);
    op(4'h4, a, 8'h00);
    chk(nm, e, sfr_rdata);
  endtask : rd_chk
  task automatic bit_chk(string nm, logic [7:0] a, logic e);
    op(4'h1, a, 8'h00);
    chk(nm, {7'h0, e}, {7'h0, bit_rdata});
  endtask : bit_chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #20000;
    failures++;
    tally_and_finish();
  end
  initial
  begin
    sys_rst = 1'b1;
    sfr = '0;
    {interrupt_enable_reg, timer_control_reg, std_prio, std_req} = '0;
    {ext0_in_n, ext1_in_n, pin_drive} = 6'h3f;
    tick(3);
    sys_rst = 1'b0;
    rd_chk("ctrl", EIE_CTRL_ADDR, 8'h00);
    rd_chk("port", EIE_PORT_ADDR, 8'hff);
    op(4'h8, EIE_PORT_ADDR, 8'h0a);
    tick(3);
    rd_chk("port", EIE_PORT_ADDR, 8'hfa);
    chk("oe", 8'h05, {4'h0, aux_port_oe});
    op(4'h8, EIE_PORT_ADDR, 8'hf5);
    op(4'h2, 8'hd9, 8'h01);
    tick(3);
    rd_chk("port", EIE_PORT_ADDR, 8'hf7);
    bit_chk("pin2", 8'hda, 1'b1);
    bit_chk("pin3", 8'hdb, 1'b0);
    op(4'h8, EIE_PORT_ADDR, 8'hff);
    op(4'h2, 8'hc2, 8'h01);
    rd_chk("ctrl", EIE_CTRL_ADDR, 8'h04);
    bit_chk("enable", 8'hc2, 1'b1);
    op(4'h2, 8'hc2, 8'h00);
    op(4'h8, 8'he0, 8'h5a);
    rd_chk("unmapped", 8'he0, 8'h00);
    op(4'h8, EIE_CTRL_ADDR, 8'h01);
    interrupt_enable_reg = 8'h80;
    pin_drive = 4'hb;
    tick(10);
    chk("req", 8'h00, {7'h0, irq_req});
    chk("wake", 8'h00, {7'h0, wake});
    rd_chk("ctrl", EIE_CTRL_ADDR, 8'h03);
    pin_drive = 4'hf;
    op(4'h8, EIE_CTRL_ADDR, 8'h00);
    foreach (rows[i])
    begin
      r = rows[i];
      op(4'h8, EIE_CTRL_ADDR, r.ctrl);
      {interrupt_enable_reg, timer_control_reg, std_req, std_prio} = {r.ie, r.tc, r.req, r.prio};
      {ext1_in_n, ext0_in_n, pin_drive} = {r.ext_n, r.pins};
      n = 0;
      while (irq_req !== 1'b1 && n < 40)
      begin
        tick(1);
        n++;
      end
      chk("posted", 8'h01, {7'h0, irq_req});
      chk("wake", 8'h01, {7'h0, wake});
      chk("ext flags", {6'h0, ~r.ext_n}, {6'h0, ext1_flag, ext0_flag});
      chk("source", {5'h0, r.src}, {5'h0, irq_src});
      chk("vector", 8'h03 + {2'h0, r.src, 3'h0}, irq_vector);
      chk("high", {7'h0, r.high}, {7'h0, irq_high});
      tick(2);
      {ext1_in_n, ext0_in_n, pin_drive, std_req} = {6'h3f, 6'h00};
      tick(12);
      rd_chk("ctrl", EIE_CTRL_ADDR, r.ctrl);
      op(4'h8, EIE_CTRL_ADDR, 8'h00);
    end
    op(4'h8, EIE_PORT_ADDR, 8'h00);
    op(4'h8, EIE_CTRL_ADDR, 8'h88);
    sys_rst = 1'b1;
    tick(3);
    sys_rst = 1'b0;
    rd_chk("ctrl", EIE_CTRL_ADDR, 8'h00);
    rd_chk("port", EIE_PORT_ADDR, 8'hff);
    tally_and_finish();
  end
endmodule : eie_top_bench
